// [design/hs_seq_pkg.sv]
// Shared constants and types for the two-byte handshake output sequencer
package hs_seq_pkg;

  // Core clock period in ns
  localparam int CLK_PERIOD_NS = 5;

  // Fixed oscillator division ratio in crystal configuration
  localparam int OSC_DIV_RATIO = 58;
  // Oscillator rising edges per half period of the divided clock
  localparam int OSC_HALF_DIV = OSC_DIV_RATIO / 2;
  localparam int DIV_CNT_W = 6;
  localparam logic [DIV_CNT_W-1:0] DIV_CNT_LAST =
    DIV_CNT_W'(OSC_HALF_DIV - 1);

  // Result widths
  localparam int RESULT_W = 12;
  localparam int HIGH_BYTE_W = 6;
  localparam int LOW_BYTE_W = 8;
  // Position of result bit 9 within the magnitude vector
  localparam int HIGH_MAG_LSB = 8;

  // Index of each synchronised pin in the pin vector
  localparam int PIN_MODE = 0;
  localparam int PIN_SEND = 1;
  localparam int PIN_LOAD = 2;
  localparam int PIN_UGATE = 3;
  localparam int PIN_LGATE = 4;
  localparam int NUM_PINS = 5;

  // Reset values
  localparam logic CTL_IDLE = 1'b1;
  localparam logic [NUM_PINS-1:0] PINS_RESET = 5'h1E;

  // Output sequence states
  typedef enum logic [3:0] {
    SEQ_IDLE,
    SEQ_WAIT_HI,
    SEQ_HI_GO,
    SEQ_HI_LOAD,
    SEQ_HI_HOLD,
    SEQ_HI_REL,
    SEQ_LO_LOAD,
    SEQ_LO_HOLD,
    SEQ_LO_REL
  } seq_state_type;

endpackage : hs_seq_pkg

// [design/int_clk_if.sv]
// Internal clock level and edge events passed from scaler to sequencer
`timescale 1ns/10ps
interface int_clk_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport snk (input level, input rise, input fall);
endinterface : int_clk_if

// [design/int_clk_scaler.sv]
// Oscillator pin sampler and fixed divider making the internal clock
`timescale 1ns/10ps
module int_clk_scaler
  import hs_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstN,
  input wire logic oscPin,
  input wire logic oscSelectPin,
  int_clk_if.src clkIf
);

  typedef struct packed {
    logic [2:0] oscSync;
    logic oscFilt;
    logic [2:0] selSync;
    logic selFilt;
    logic [DIV_CNT_W-1:0] divCnt;
    logic divClk;
    logic level;
    logic rise;
    logic fall;
  } scaler_state_type;

  scaler_state_type r;
  scaler_state_type n;
  logic oscRise;

  // Sampling, division and edge events
  always_comb begin
    n = r;
    n.oscSync = {r.oscSync[1:0], oscPin};
    n.selSync = {r.selSync[1:0], oscSelectPin};
    // Accept a change only when stages two and three agree
    if (r.oscSync[1] == r.oscSync[2]) begin
      n.oscFilt = r.oscSync[2];
    end
    if (r.selSync[1] == r.selSync[2]) begin
      n.selFilt = r.selSync[2];
    end
    oscRise = n.oscFilt & ~r.oscFilt;
    // Divided clock toggles every half ratio of oscillator edges
    if (oscRise) begin
      if (r.divCnt == DIV_CNT_LAST) begin
        n.divCnt = '0;
        n.divClk = ~r.divClk; // RULE_18
      end else begin
        n.divCnt = r.divCnt + DIV_CNT_W'(1);
      end
    end
    // Select high follows the oscillator with its own duty cycle
    n.level = r.selFilt ? r.oscFilt : r.divClk; // RULE_17 RULE_19
    n.rise = n.level & ~r.level;
    n.fall = ~n.level & r.level;
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign clkIf.level = r.level;
  assign clkIf.rise = r.rise;
  assign clkIf.fall = r.fall;

endmodule : int_clk_scaler

// [design/two_byte_handshake_output_sequencer.sv]
// Two-byte handshake output sequencer with result latches and pin control
`timescale 1ns/10ps

// Notes on behaviour
// RULE_01: With mode high, enter handshake after each new result is latched.
// RULE_02: A rising mode edge enters handshake at once, anywhere in a cycle.
// RULE_03: A mode edge during a latch write waits until data is stable.
// RULE_04: In handshake, mode is ignored and latch updates are blocked.
// RULE_05: Mode high or handshake active drives load and both gate pins.
// RULE_06: Receiver holds ready high only while it can take a byte.
// RULE_07: Sample ready on a falling tick; next rise starts the high byte.
// RULE_08: High byte: strobe low one period, data 1.5, upper gate two.
// RULE_09: Receiver captures the byte on the strobe's rising edge.
// RULE_10: Ready low after the load holds upper gate low and data driven.
// RULE_11: Ready back high: data off at next fall, gate high half later.
// RULE_12: Low byte: strobe and lower gate low with low data enabled.
// RULE_13: Ready high on a fall ends data; half later handshake clears.
// RULE_14: Cycle ends after both bytes, back to normal output behaviour.
// RULE_15: Entered with ready low, the whole sequence waits on ready.
// RULE_16: A result finishing during handshake is discarded.
// RULE_17: Select high or open: internal clock equals the oscillator.
// RULE_18: Select low: internal clock is oscillator divided by 58.
// RULE_19: An overdriven oscillator sets duty, frequency and phase exactly; the code follows it only with select high, a few core clocks late.
// RULE_20: Outside handshake with mode low, the three pins gate bytes.
// RULE_21: After reset: idle, outputs off, pins driven only if mode high.
module two_byte_handshake_output_sequencer
  import hs_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic oscPin,
  input wire logic oscSelectPin,
  input wire logic modePin,
  input wire logic txBufferEmptyFlag,
  input wire logic convDone,
  input wire logic [RESULT_W-1:0] resultMag,
  input wire logic resultSign,
  input wire logic resultOverrange,
  input wire logic txBufferLoadStrobeIn,
  output logic txBufferLoadStrobeOut,
  output logic txBufferLoadStrobeOe,
  input wire logic upperByteGateIn,
  output logic upperByteGateOut,
  output logic upperByteGateOe,
  input wire logic lowerByteGateIn,
  output logic lowerByteGateOut,
  output logic lowerByteGateOe,
  output logic [HIGH_BYTE_W-1:0] highDataOut,
  output logic highDataOe,
  output logic [LOW_BYTE_W-1:0] lowDataOut,
  output logic lowDataOe,
  output logic handshakeActive
);

  // Whole state of the sequencer
  typedef struct packed {
    logic [NUM_PINS-1:0] syncA;
    logic [NUM_PINS-1:0] syncB;
    logic [NUM_PINS-1:0] syncC;
    logic [NUM_PINS-1:0] pinFilt;
    logic modePrev;
    logic pendEntry;
    logic convWrite;
    logic hsActive;
    seq_state_type state;
    logic [RESULT_W-1:0] latchMag;
    logic latchSign;
    logic latchOvr;
    logic loadOut;
    logic ugOut;
    logic lgOut;
    logic ctlOe;
    logic [HIGH_BYTE_W-1:0] hiData;
    logic hiOe;
    logic [LOW_BYTE_W-1:0] loData;
    logic loOe;
  } seq_regs_type;

  seq_regs_type r;
  seq_regs_type n;

  logic [1:0] rstSync_ff;
  logic rstN;
  logic [NUM_PINS-1:0] pinsRaw;
  logic modeLvl;
  logic sendLvl;
  logic modeRise;
  logic wantEntry;
  logic directMode;

  int_clk_if clkIf ();

  // Reset released through two flops so all logic leaves reset together
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync_ff <= 2'h0;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end

  assign rstN = rstSync_ff[1];

  // Internal clock generation from the oscillator pin
  int_clk_scaler u_scaler (
    .core_clk(core_clk),
    .rstN(rstN),
    .oscPin(oscPin),
    .oscSelectPin(oscSelectPin),
    .clkIf(clkIf)
  );

  // Pins gathered so one synchroniser handles them all
  always_comb begin
    pinsRaw = '0;
    pinsRaw[PIN_MODE] = modePin;
    pinsRaw[PIN_SEND] = txBufferEmptyFlag;
    pinsRaw[PIN_LOAD] = txBufferLoadStrobeIn;
    pinsRaw[PIN_UGATE] = upperByteGateIn;
    pinsRaw[PIN_LGATE] = lowerByteGateIn;
  end

  // Next state of the whole block
  always_comb begin
    n = r;

    // Three-stage pin sampling, change taken when stages agree
    n.syncA = pinsRaw;
    n.syncB = r.syncA;
    n.syncC = r.syncB;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (r.syncB[i] == r.syncC[i]) begin
        n.pinFilt[i] = r.syncC[i];
      end
    end

    modeLvl = r.pinFilt[PIN_MODE];
    sendLvl = r.pinFilt[PIN_SEND];
    modeRise = modeLvl & ~r.modePrev;
    n.modePrev = modeLvl;

    // Latch write; a result arriving mid-handshake is dropped
    n.convWrite = 1'b0;
    if (convDone && !r.hsActive) begin // RULE_04 RULE_16
      n.latchMag = resultMag;
      n.latchSign = resultSign;
      n.latchOvr = resultOverrange;
      n.convWrite = 1'b1;
    end

    // Entry: mode edge, postponed edge, or latch done with mode high
    wantEntry = modeRise | r.pendEntry | // RULE_02
      (r.convWrite & modeLvl); // RULE_01
    if (r.hsActive) begin
      n.pendEntry = 1'b0; // RULE_04
    end else if (wantEntry) begin
      if (convDone) begin
        // Latches change this cycle, so wait a cycle
        n.pendEntry = 1'b1; // RULE_03
      end else begin
        n.pendEntry = 1'b0;
        n.hsActive = 1'b1;
        n.state = SEQ_WAIT_HI;
      end
    end

    // Output cycle paced by internal clock edges and ready
    case (r.state)
      SEQ_IDLE: begin
        n.loadOut = CTL_IDLE;
        n.ugOut = CTL_IDLE;
        n.lgOut = CTL_IDLE;
      end
      SEQ_WAIT_HI: begin
        // Ready sensed on a falling internal edge
        if (clkIf.fall && sendLvl) begin // RULE_07 RULE_15
          n.state = SEQ_HI_GO;
        end
      end
      SEQ_HI_GO: begin
        if (clkIf.rise) begin
          n.loadOut = 1'b0; // RULE_07
          n.ugOut = 1'b0;
          n.hiOe = 1'b1;
          n.state = SEQ_HI_LOAD;
        end
      end
      SEQ_HI_LOAD: begin
        // Strobe low for one full internal period
        if (clkIf.rise) begin
          n.loadOut = 1'b1; // RULE_08
          n.state = SEQ_HI_HOLD;
        end
      end
      SEQ_HI_HOLD: begin
        // Stalls here with data and gate held until ready returns
        if (clkIf.fall && sendLvl) begin // RULE_10
          n.hiOe = 1'b0; // RULE_11 RULE_08
          n.state = SEQ_HI_REL;
        end
      end
      SEQ_HI_REL: begin
        // Gate released half a period after data goes off
        if (clkIf.rise) begin
          n.ugOut = 1'b1; // RULE_11 RULE_08
          n.loadOut = 1'b0; // RULE_12
          n.lgOut = 1'b0;
          n.loOe = 1'b1;
          n.state = SEQ_LO_LOAD;
        end
      end
      SEQ_LO_LOAD: begin
        if (clkIf.rise) begin
          n.loadOut = 1'b1; // RULE_12
          n.state = SEQ_LO_HOLD;
        end
      end
      SEQ_LO_HOLD: begin
        if (clkIf.fall && sendLvl) begin // RULE_13 RULE_15
          n.loOe = 1'b0;
          n.state = SEQ_LO_REL;
        end
      end
      SEQ_LO_REL: begin
        // Both bytes gone: leave handshake half a period later
        if (clkIf.rise) begin
          n.loadOut = CTL_IDLE; // RULE_13
          n.ugOut = CTL_IDLE;
          n.lgOut = CTL_IDLE;
          n.hsActive = 1'b0; // RULE_14
          n.state = SEQ_IDLE;
        end
      end
      default: begin
        n.state = SEQ_IDLE;
        n.hsActive = 1'b0;
      end
    endcase

    // Control pins become outputs with mode high or in handshake
    n.ctlOe = n.pinFilt[PIN_MODE] | n.hsActive; // RULE_05

    // Direct access: host pins gate the bytes while mode is low outside handshake
    directMode = ~r.hsActive & ~n.hsActive & ~modeLvl;
    if (directMode) begin // RULE_20
      n.hiOe = ~r.pinFilt[PIN_LOAD] & ~r.pinFilt[PIN_UGATE];
      n.loOe = ~r.pinFilt[PIN_LOAD] & ~r.pinFilt[PIN_LGATE];
    end else if (!r.hsActive) begin
      // Mode high but idle: bus stays released
      n.hiOe = 1'b0;
      n.loOe = 1'b0;
    end

    // Data follows the latches, which hold still during handshake
    n.hiData = {r.latchOvr, r.latchSign,
      r.latchMag[RESULT_W-1:HIGH_MAG_LSB]};
    n.loData = r.latchMag[LOW_BYTE_W-1:0];
  end

  // Single state register; reset leaves everything idle and released
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      r <= '0; // RULE_21
      r.syncA <= PINS_RESET;
      r.syncB <= PINS_RESET;
      r.syncC <= PINS_RESET;
      r.pinFilt <= PINS_RESET;
      r.state <= SEQ_IDLE;
      r.loadOut <= CTL_IDLE;
      r.ugOut <= CTL_IDLE;
      r.lgOut <= CTL_IDLE;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign txBufferLoadStrobeOut = r.loadOut;
  assign txBufferLoadStrobeOe = r.ctlOe;
  assign upperByteGateOut = r.ugOut;
  assign upperByteGateOe = r.ctlOe;
  assign lowerByteGateOut = r.lgOut;
  assign lowerByteGateOe = r.ctlOe;
  assign highDataOut = r.hiData;
  assign highDataOe = r.hiOe;
  assign lowDataOut = r.loData;
  assign lowDataOe = r.loOe;
  assign handshakeActive = r.hsActive;

endmodule : two_byte_handshake_output_sequencer

// [verification/hs_seq_asserts.sv]
// Port-level assertions for the handshake output sequencer
`timescale 1ns/10ps
module hs_seq_asserts
  import hs_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic modePin,
  input wire logic txBufferLoadStrobeOut,
  input wire logic txBufferLoadStrobeOe,
  input wire logic upperByteGateOut,
  input wire logic upperByteGateOe,
  input wire logic lowerByteGateOut,
  input wire logic lowerByteGateOe,
  input wire logic [HIGH_BYTE_W-1:0] highDataOut,
  input wire logic highDataOe,
  input wire logic [LOW_BYTE_W-1:0] lowDataOut,
  input wire logic lowDataOe,
  input wire logic handshakeActive
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // A low strobe on an undriven pin would never reach the receiver
  a_strobe_drive:
    assert property (!txBufferLoadStrobeOut |-> txBufferLoadStrobeOe)
    else $error("strobe low while not driven");
  // Mode held high longer than the filter takes over all three pins
  a_mode_drives:
    assert property (modePin [*8] |->
      txBufferLoadStrobeOe && upperByteGateOe && lowerByteGateOe)
    else $error("mode high but pins not driven");
  a_mode_entry:
    assert property ($rose(modePin) && !handshakeActive ##1 modePin [*7]
      |-> handshakeActive)
    else $error("mode edge did not enter handshake");
  a_high_start:
    assert property ($fell(upperByteGateOut) |->
      !txBufferLoadStrobeOut && highDataOe && handshakeActive)
    else $error("high byte start malformed");
  a_low_start:
    assert property ($fell(lowerByteGateOut) |->
      !txBufferLoadStrobeOut && lowDataOe && $rose(upperByteGateOut))
    else $error("low byte start malformed");
  // High data drops before the upper gate is released
  a_high_data_gate:
    assert property (highDataOe && handshakeActive |->
      !upperByteGateOut && !lowDataOe)
    else $error("high data without upper gate");
  a_data_frozen:
    assert property (handshakeActive && $past(handshakeActive) |->
      $stable(highDataOut) && $stable(lowDataOut))
    else $error("latches changed in handshake");
  a_idle_release:
    assert property ($fell(handshakeActive) |-> txBufferLoadStrobeOut &&
      upperByteGateOut && lowerByteGateOut && !highDataOe && !lowDataOe)
    else $error("handshake end left pins active");
endmodule : hs_seq_asserts

bind two_byte_handshake_output_sequencer hs_seq_asserts chk (.core_clk,
  .nrst, .modePin, .txBufferLoadStrobeOut, .txBufferLoadStrobeOe,
  .upperByteGateOut, .upperByteGateOe, .lowerByteGateOut, .lowerByteGateOe,
  .highDataOut, .highDataOe, .lowDataOut, .lowDataOe, .handshakeActive);

// [verification/uart_tx_buffer_model.sv]
// Behavioural receiving transmitter buffer with an empty flag
`timescale 1ns/10ps
module uart_tx_buffer_model (
  input wire logic core_clk,
  input wire logic loadStrobePin,
  input wire logic [7:0] busPins,
  input wire logic holdOff,
  input wire logic [31:0] busyCycles,
  output logic txBufferEmptyFlag
);
  logic [7:0] gotBytes[$];
  logic strobeSeen = 1'h1;
  logic [31:0] busyCnt = 32'h0;
  // Take the byte on the strobe rise, then stay busy a while
  always @(posedge core_clk) begin
    strobeSeen <= loadStrobePin;
    if (loadStrobePin && !strobeSeen) begin
      gotBytes.push_back(busPins);
      busyCnt <= busyCycles + 32'h1;
    end else if (busyCnt != 32'h0) begin
      busyCnt <= busyCnt - 32'h1;
    end
  end
  // Ready only while empty and not held off by the bench
  assign txBufferEmptyFlag = !holdOff && busyCnt == 32'h0;
endmodule : uart_tx_buffer_model

// [verification/two_byte_handshake_output_sequencer_test.sv]
// Self-checking bench for the handshake output sequencer
`timescale 1ns/10ps
`define CHK(g, e) cmp(32'(g), 32'(e));
module two_byte_handshake_output_sequencer_test
  import hs_seq_pkg::*;
;
  logic core_clk = 1'h0, nrst = 1'h0, oscPin = 1'h0, oscSel = 1'h1;
  logic modePin = 1'h0, convDone = 1'h0, sign = 1'h0, ovr = 1'h0;
  logic hold = 1'h0, tbStb = 1'h1, tbUg = 1'h1, tbLg = 1'h1;
  logic [RESULT_W-1:0] mag = 12'h0;
  logic stbOut, stbOe, ugOut, ugOe, lgOut, lgOe, hiOe, loOe, hsAct, ready;
  logic [HIGH_BYTE_W-1:0] hiData;
  logic [LOW_BYTE_W-1:0] loData;
  logic [31:0] busy = 32'h2;
  int cyc = 0, err_total = 0, total_checks = 0;
  time tS, tH, tU, wS, wH, wU;
  // Undriven pins sit at their pull-up or the bench's level
  wire stbPin = stbOe ? stbOut : tbStb;
  wire ugPin = ugOe ? ugOut : tbUg;
  wire lgPin = lgOe ? lgOut : tbLg;
  // Released data lines show a pattern that changes every cycle
  wire [7:0] bus = loOe ? loData : hiOe ? {2'h0, hiData} : cyc[7:0];
  always #2.5 core_clk = ~core_clk;
  always #50 oscPin = ~oscPin;
  two_byte_handshake_output_sequencer DUT (.core_clk, .nrst, .oscPin,
    .oscSelectPin(oscSel), .modePin, .txBufferEmptyFlag(ready), .convDone,
    .resultMag(mag), .resultSign(sign), .resultOverrange(ovr),
    .txBufferLoadStrobeIn(stbPin), .txBufferLoadStrobeOut(stbOut),
    .txBufferLoadStrobeOe(stbOe), .upperByteGateIn(ugPin),
    .upperByteGateOut(ugOut), .upperByteGateOe(ugOe),
    .lowerByteGateIn(lgPin), .lowerByteGateOut(lgOut),
    .lowerByteGateOe(lgOe), .highDataOut(hiData), .highDataOe(hiOe),
    .lowDataOut(loData), .lowDataOe(loOe), .handshakeActive(hsAct));
  uart_tx_buffer_model far (.core_clk, .loadStrobePin(stbPin),
    .busPins(bus), .holdOff(hold), .busyCycles(busy),
    .txBufferEmptyFlag(ready));
  // Pulse widths in ns, measured on the pins themselves
  always @(negedge stbPin) tS = $time;
  always @(posedge stbPin) wS = $time - tS;
  always @(negedge ugPin) tU = $time;
  always @(posedge ugPin) wU = $time - tU;
  always @(posedge hiOe) tH = $time;
  always @(negedge hiOe) wH = $time - tH;
  // Cycle ceiling; the divided-clock run is the longest part
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic conv(input logic [11:0] m, input logic s, input logic o);
    mag = m;
    sign = s;
    ovr = o;
    convDone = 1'h1;
    tick(1);
    convDone = 1'h0;
  endtask : conv
  task automatic pulse();
    modePin = 1'h1;
    tick(10);
    modePin = 1'h0;
  endtask : pulse
  // Bounded wait for a whole handshake cycle
  task automatic hs_done(input int lim);
    int n;
    n = 0;
    while (hsAct !== 1'h1 && n < 40) begin
      tick(1);
      n++;
    end
    `CHK(hsAct, 1'h1)
    while (hsAct !== 1'h0 && n < lim) begin
      tick(1);
      n++;
    end
    `CHK(n < lim, 1'h1)
  endtask : hs_done
  task automatic pair(input logic [5:0] hi, input logic [7:0] lo);
    `CHK(far.gotBytes.size(), 2)
    if (far.gotBytes.size() == 2) begin
      `CHK(far.gotBytes.pop_front(), {2'h0, hi})
      `CHK(far.gotBytes.pop_front(), lo)
    end
    far.gotBytes.delete();
  endtask : pair
  task automatic report_and_stop();
    $display("Checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    tick(3);
    nrst = 1'h1;
    tick(12);
    `CHK({stbOe, ugOe, lgOe, hiOe, loOe, hsAct}, 6'h00)
    // Direct reads with mode low
    conv(12'hA5C, 1'h1, 1'h0);
    tbStb = 1'h0;
    tbUg = 1'h0;
    tick(12);
    `CHK({hiOe, loOe, hiData}, 8'h9A)
    tbUg = 1'h1;
    tbLg = 1'h0;
    tick(12);
    `CHK({hiOe, loOe, loData}, 10'h15C)
    tbStb = 1'h1;
    tbLg = 1'h1;
    // Strobe release in direct mode looks like a load to the receiver
    tick(2);
    far.gotBytes.delete();
    // Raising mode is itself an edge, so the old result goes out first
    modePin = 1'h1;
    tick(12);
    `CHK({stbOe, ugOe, lgOe, stbPin}, 4'hF)
    hs_done(400);
    pair(6'h1A, 8'h5C);
    // Mode held high: each conversion end sends both bytes
    conv(12'h3C7, 1'h0, 1'h1);
    hs_done(400);
    pair(6'h23, 8'hC7);
    `CHK(wS, 100)
    `CHK(wH, 150)
    `CHK(wU, 200)
    `CHK({stbOe, stbPin, ugPin, lgPin, hiOe, loOe}, 6'h3C)
    // Slow receiver stalls; a result arriving meanwhile is lost
    busy = 32'h12C;
    conv(12'hF01, 1'h1, 1'h1);
    tick(50);
    conv(12'h0FE, 1'h0, 1'h0);
    hs_done(3000);
    pair(6'h3F, 8'h01);
    `CHK(wU > 1500, 1'h1)
    `CHK(wH > 1500, 1'h1)
    // Triggered by a mode pulse while ready is low
    modePin = 1'h0;
    busy = 32'h2;
    hold = 1'h1;
    tick(12);
    pulse();
    tick(100);
    `CHK({hsAct, stbPin, ugPin}, 3'h7)
    hold = 1'h0;
    hs_done(400);
    pair(6'h3F, 8'h01);
    // Filtered mode edge lands in the very cycle a result is written
    modePin = 1'h1;
    tick(4);
    conv(12'h5A3, 1'h0, 1'h0);
    `CHK(hsAct, 1'h0)
    tick(1);
    `CHK(hsAct, 1'h1)
    modePin = 1'h0;
    hs_done(400);
    pair(6'h05, 8'hA3);
    // Divided internal clock
    oscSel = 1'h0;
    tick(20);
    pulse();
    hs_done(12000);
    pair(6'h05, 8'hA3);
    `CHK(wS, 5800)
    report_and_stop();
  end
endmodule : two_byte_handshake_output_sequencer_test
